// file: bram_rst_seq_pkg.sv
// Purpose: Constants and states for the block memory reset sequencer
// Assumes: One clock, i_clock at 200 MHz
// Notes:   Function
// Function
// - The global set/reset input of the memory is treated as asynchronous to its clocks.
// - In FIFO use global reset is always enabled and the strobes act as the clock enables.
// - Full FIFO reset and read pointer reset are asynchronous inputs of the memory.
// - With synchronous reset and global reset disabled, no ordering applies.
package bram_rst_seq_pkg;
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned GAP_CYCLES   = 1;
  localparam int unsigned RST_CYCLES   = 1;
  localparam logic [1:0]  CNT_RST      = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DROP    = 3'b001,
    ST_RESET   = 3'b010,
    ST_RELEASE = 3'b011,
    ST_DONE    = 3'b100
  } seq_state_t;
endpackage : bram_rst_seq_pkg

// file: block_ram_reset_sequencer.sv
// Purpose: Orders memory resets against its clock enables or FIFO strobes
// Assumes: Requests and enables come from logic on i_clock
// Notes:   Reset outputs feed asynchronous memory reset inputs
`timescale 1ns/10ps
`default_nettype none
module block_ram_reset_sequencer (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_req_full,
  input  wire logic i_req_rdptr,
  input  wire logic i_sync_mode,
  input  wire logic i_wr_en,
  input  wire logic i_rd_en,
  output var  logic o_wr_en,
  output var  logic o_rd_en,
  output var  logic o_global_set_reset,
  output var  logic o_read_pointer_reset,
  output var  logic o_busy,
  output var  logic o_done
);
  bram_rst_seq_pkg::seq_state_t state_r, state_nxt;
  logic [1:0] cnt_r;
  logic       full_r;
  logic       full_nxt;
  wire logic  req_any   = i_req_full | i_req_rdptr;
  wire logic  cnt_end   = cnt_r == 2'(bram_rst_seq_pkg::GAP_CYCLES - 1);
  wire logic  in_seq    = state_r != bram_rst_seq_pkg::ST_IDLE
                       && state_r != bram_rst_seq_pkg::ST_DONE;
  wire logic  in_rst    = state_r == bram_rst_seq_pkg::ST_RESET;
  // Read pointer reset gates only the read strobe; full reset gates both
  wire logic  gate_wr   = in_seq & full_r & ~i_sync_mode;
  wire logic  gate_rd   = in_seq & ~i_sync_mode;
  // Synchronous mode: no ordering needed, reset pulses with enables live
  wire logic  sync_go   = i_sync_mode & req_any & (state_r == bram_rst_seq_pkg::ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    full_nxt  = full_r;
    unique case (state_r)
      bram_rst_seq_pkg::ST_IDLE, bram_rst_seq_pkg::ST_DONE: begin
        if (req_any & ~i_sync_mode) begin
          state_nxt = bram_rst_seq_pkg::ST_DROP;
          full_nxt  = i_req_full;
        end else begin
          state_nxt = bram_rst_seq_pkg::ST_IDLE;
        end
      end
      bram_rst_seq_pkg::ST_DROP:
        if (cnt_end) state_nxt = bram_rst_seq_pkg::ST_RESET;
      bram_rst_seq_pkg::ST_RESET:
        state_nxt = bram_rst_seq_pkg::ST_RELEASE;
      bram_rst_seq_pkg::ST_RELEASE:
        if (cnt_end) state_nxt = bram_rst_seq_pkg::ST_DONE;
      default: state_nxt = bram_rst_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= bram_rst_seq_pkg::ST_IDLE;
      cnt_r   <= bram_rst_seq_pkg::CNT_RST;
      full_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      full_r  <= full_nxt;
      cnt_r   <= (state_nxt != state_r) ? bram_rst_seq_pkg::CNT_RST : cnt_r + 2'h1;
    end
  end

  // All outputs registered; read enable, and write enable for a full reset, are forced low while the sequence runs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_wr_en              <= 1'b0;
      o_rd_en              <= 1'b0;
      o_global_set_reset   <= 1'b0;
      o_read_pointer_reset <= 1'b0;
      o_busy               <= 1'b0;
      o_done               <= 1'b0;
    end else begin
      o_wr_en              <= i_wr_en & ~(gate_wr | (state_nxt != bram_rst_seq_pkg::ST_IDLE
                              && state_nxt != bram_rst_seq_pkg::ST_DONE && full_nxt
                              && !i_sync_mode));
      o_rd_en              <= i_rd_en & ~(gate_rd | (state_nxt != bram_rst_seq_pkg::ST_IDLE
                              && state_nxt != bram_rst_seq_pkg::ST_DONE && !i_sync_mode));
      o_global_set_reset   <= (state_nxt == bram_rst_seq_pkg::ST_RESET && full_nxt)
                              | (sync_go & i_req_full);
      o_read_pointer_reset <= (state_nxt == bram_rst_seq_pkg::ST_RESET && !full_nxt)
                              | (sync_go & i_req_rdptr & ~i_req_full);
      o_busy               <= state_nxt != bram_rst_seq_pkg::ST_IDLE
                              && state_nxt != bram_rst_seq_pkg::ST_DONE;
      o_done               <= state_nxt == bram_rst_seq_pkg::ST_DONE;
    end
  end

  // Synchronous mode is exempt from ordering, so the ordering checks skip it
  AST_DROP_BEFORE_RST: assert property (@(posedge i_clock) disable iff (i_rst)
    ($rose(o_global_set_reset) && !i_sync_mode) |-> $past(!o_wr_en && !o_rd_en))
    else $error("reset asserted with enables high");
  AST_HOLD_AFTER_RST: assert property (@(posedge i_clock) disable iff (i_rst)
    ($fell(o_global_set_reset) && !i_sync_mode) |-> !o_wr_en && !o_rd_en)
    else $error("enables returned too early");
  AST_RD_GATED: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_read_pointer_reset && !i_sync_mode) |-> !o_rd_en)
    else $error("read strobe live during pointer reset");
  AST_DONE_FOLLOWS: assert property (@(posedge i_clock) disable iff (i_rst)
    ($fell(o_global_set_reset) && !i_sync_mode) |-> ##[1:3] o_done)
    else $error("done missing after reset");
  AST_WR_GATED: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_global_set_reset && !i_sync_mode) |-> !o_wr_en)
    else $error("write strobe live during full reset");
  AST_RST_ONE: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_busy && o_global_set_reset) |=> !o_global_set_reset)
    else $error("reset pulse too long");
  AST_SYNC_FREE: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_sync_mode && state_r == bram_rst_seq_pkg::ST_IDLE) |=> !o_busy)
    else $error("sequence ran in sync mode");
  AST_BUSY_DONE: assert property (@(posedge i_clock) disable iff (i_rst)
    o_done |-> !o_busy)
    else $error("done while busy");
  COV_FULL: cover property (@(posedge i_clock) o_global_set_reset ##[1:4] o_done);
  COV_RDPTR: cover property (@(posedge i_clock) o_read_pointer_reset ##[1:4] o_done);
  COV_SYNC: cover property (@(posedge i_clock) i_sync_mode && o_global_set_reset);
endmodule : block_ram_reset_sequencer
`default_nettype wire

// file: user_logic_model.sv
// Purpose: User logic model that raises reset requests
// Assumes: Bench moves i_cmd 1 ns after a rising edge
// Notes:   Bit 0 asks for full reset, bit 1 for read pointer reset
`timescale 1ns/10ps
`default_nettype none
module user_logic_model (
  input  wire logic [1:0] i_cmd,
  output var  logic       o_req_full,
  output var  logic       o_req_rdptr
);
  assign o_req_full  = i_cmd[0];
  assign o_req_rdptr = i_cmd[1];
endmodule : user_logic_model
`default_nettype wire

// file: block_ram_reset_sequencer_tb.sv
// Purpose: Self-checking bench for the block memory reset sequencer
// Assumes: Inputs move 1 ns after a rising edge, strobes held high
// Notes:   Cycle counts follow the hand-over walk, so no open waits
`timescale 1ns/10ps
`default_nettype none
module block_ram_reset_sequencer_tb;
  logic       i_clock = 1'b0, i_rst = 1'b1, sync_mode = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic       rq_f, rq_r, o_we, o_rd, o_glob, o_rdp, o_busy, o_done;
  int         err_total = 0, tests_run = 0;
  wire  [5:0] outs = {o_we, o_rd, o_glob, o_rdp, o_busy, o_done};
  always #2.5 i_clock = ~i_clock;
  user_logic_model i_model (.i_cmd(cmd), .o_req_full(rq_f), .o_req_rdptr(rq_r));
  block_ram_reset_sequencer i_dut (.i_clock, .i_rst, .i_req_full(rq_f), .i_req_rdptr(rq_r),
    .i_sync_mode(sync_mode), .i_wr_en(1'b1), .i_rd_en(1'b1), .o_wr_en(o_we), .o_rd_en(o_rd),
    .o_global_set_reset(o_glob), .o_read_pointer_reset(o_rdp), .o_busy, .o_done);
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step
  // Expected {we, rd, glob, rdp, busy, done} from the taking edge on, five cycles
  task automatic run_req(input logic sm, input logic [1:0] c, input logic [29:0] e);
    sync_mode = sm;
    cmd = c;
    for (int k = 4; k >= 0; k--) begin
      step(1);
      cmd = 2'h0;
      check(outs, e[k*6+:6]);
    end
    $display("Test done: sync %0d request %0d", sm, c);
  endtask : run_req
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    step(12);
    check(outs, 6'h00);
    i_rst = 1'b0;
    run_req(1'b0, 2'h1, {6'h02, 6'h0a, 6'h02, 6'h01, 6'h30});
    run_req(1'b0, 2'h2, {6'h22, 6'h26, 6'h22, 6'h21, 6'h30});
    run_req(1'b0, 2'h3, {6'h02, 6'h0a, 6'h02, 6'h01, 6'h30});
    run_req(1'b1, 2'h1, {6'h38, 6'h30, 6'h30, 6'h30, 6'h30});
    run_req(1'b1, 2'h2, {6'h34, 6'h30, 6'h30, 6'h30, 6'h30});
    report_and_stop();
  end
endmodule : block_ram_reset_sequencer_tb
`default_nettype wire
